// ---- pkg/sdrc_pkg.sv ----
package sdrc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MRD_TIME_NS = 50;
  localparam int MRD_CYC = (MRD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] MRD_WAIT = 5'(MRD_CYC - 1);
  localparam logic [3:0] INIT_AREF_NUM = 4'h8;
  // Register byte offsets.
  localparam logic [7:0] OFS_RATE = 8'h00;
  localparam logic [7:0] OFS_BANK = 8'h04;
  localparam logic [7:0] OFS_GLOBAL = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  // Field positions.
  localparam int RATE_DIV_LSB = 0;
  localparam int BANK_EBE_BIT = 0;
  localparam int BANK_CWF_LSB = 4;
  localparam int GC_TRAS_LSB = 0;
  localparam int GC_TRP_LSB = 4;
  localparam int GC_CL_LSB = 8;
  localparam int GC_PSM_BIT = 12;
  localparam int GC_POWERUP_SEQUENCE_ENABLE_BIT = 13;
  localparam int GC_SELF_REFRESH_REQUEST_BIT = 14;
  localparam int ST_INIT_BIT = 4;
  localparam int ST_SREF_BIT = 5;
  localparam int ST_IDLE_BIT = 6;
  localparam int ST_REFD_BIT = 7;
  localparam int ST_MRSD_BIT = 8;
  localparam int ST_PAGE_LSB = 16;
  localparam int MR_CL_LSB = 4;
  localparam int ADDR_A10_BIT = 10;
  // Reset values.
  localparam logic [11:0] RST_REFRESH_DIVIDER = 12'h0FF;
  localparam logic [3:0] RST_TRAS = 4'h1;
  localparam logic [2:0] RST_TRP = 3'h1;
  localparam logic [1:0] RST_CL = 2'h2;
  localparam logic [12:0] PAGE_MIN_BYTES = 13'h0200;
  localparam int COL_BASE_BITS = 8;

  typedef enum logic [3:0] {
    CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
    CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_NOP = 4'h7
  } sdrc_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ACT = 4'h1, ST_RW = 4'h3, ST_PRE = 4'h2,
    ST_INIT_PRE = 4'h6, ST_INIT_REF = 4'h7, ST_MRS = 4'h5, ST_REF = 4'h4,
    ST_SREF = 4'hC, ST_SREF_EXIT = 4'hD
  } sdrc_state_e;

  // SDRAM pins: chip select, RAS, CAS and WE packed as the command.
  typedef struct packed {
    logic cke;
    sdrc_cmd_e cmd;
    logic [1:0] ba;
    logic [12:0] addr;
  } sdrc_pins_s;

  typedef struct packed {
    logic [12:0] cnt;
    logic expire;
  } sdrc_tmr_s;

  typedef struct packed {
    sdrc_state_e st;
    logic [4:0] wait_cnt;
    logic [3:0] aref_left;
    logic init_done;
    logic mrs_due;
    logic ref_due;
    logic ebe;
    logic [1:0] cwf;
    logic [11:0] refresh_divider;
    logic [3:0] tras;
    logic [2:0] trp;
    logic [1:0] cl;
    logic powerup_order_select;
    logic powerup_sequence_enable;
    logic self_refresh_request;
    logic dph_wr;
    logic [7:0] dph_ofs;
    logic [31:0] rdata;
    sdrc_pins_s pins;
    logic done;
    logic err;
    logic [12:0] page;
  } sdrc_core_s;
endpackage : sdrc_pkg

// ---- hdl/sdrc_refresh_timer.sv ----
`timescale 1ns/1ps
module sdrc_refresh_timer
  import sdrc_pkg::*;
(
  input wire logic CLOCK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic RUN, // Count only while refresh is enabled.
  input wire logic [12:0] PERIOD, // Interval in clock cycles.
  output logic EXPIRE // One-cycle pulse at each interval end.
);
  sdrc_tmr_s s_ff, nxt_s;

  // Count down and reload; a halted timer restarts a full interval.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.expire = 1'b0;
    if (!RUN) begin
      nxt_s.cnt = PERIOD - 13'h1;
    end else if (s_ff.cnt == 13'h0) begin
      nxt_s.expire = 1'b1;
      nxt_s.cnt = PERIOD - 13'h1;
    end else begin
      nxt_s.cnt = s_ff.cnt - 13'h1;
    end
  end

  // State register.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign EXPIRE = s_ff.expire;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  chk_timer_reload: assert property (EXPIRE && $past(RUN) |->
    s_ff.cnt == $past(PERIOD) - 13'h1)
    else $error("refresh timer did not reload the full period");
  chk_timer_early: assert property (RUN && s_ff.cnt != 13'h0
    |=> !EXPIRE)
    else $error("refresh timer expired before reaching zero");
endmodule : sdrc_refresh_timer

// ---- hdl/sdrc_top.sv ----
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sdrc_top
  import sdrc_pkg::*;
(
  input wire logic CLOCK, // System clock, 40 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic HSEL, // AHB slave select.
  input wire logic [31:0] HADDR, // AHB address.
  input wire logic [1:0] HTRANS, // AHB transfer type.
  input wire logic HWRITE, // AHB write flag.
  input wire logic [2:0] HSIZE, // AHB size, word only.
  input wire logic [31:0] HWDATA, // AHB write data.
  input wire logic HREADY, // AHB bus ready.
  output logic [31:0] HRDATA, // AHB read data.
  output logic HREADYOUT, // Slave ready, never stalls.
  output logic HRESP, // Always OKAY.
  input wire logic ACC_REQ, // SDRAM access request, held.
  input wire logic ACC_WRITE, // Access is a write.
  input wire logic [26:0] ACC_ADDR, // Halfword address of access.
  output logic ACC_DONE, // Transfer command issued.
  output logic ACC_ERR, // Access refused, bank disabled.
  output logic [12:0] PAGE_BYTES, // Current page size in bytes.
  output sdrc_pins_s SD_PINS // SDRAM command pins.
);
  sdrc_core_s s_ff, n;
  logic expire;
  logic [12:0] ref_period;
  logic acc_go;
  logic [3:0] column_address_bits;
  logic [26:0] acc_col;
  logic [26:0] acc_bank;
  logic [26:0] acc_row;
  logic [4:0] t_rc;
  logic [31:0] state_word;

  // Interval sums the divider with both programmed timing fields.
  assign ref_period = 13'(s_ff.refresh_divider) + 13'(s_ff.tras) + 13'(s_ff.trp);
  assign t_rc = 5'(s_ff.tras) + 5'(s_ff.trp);

  // Refresh only runs once the memory is initialised and not parked.
  sdrc_refresh_timer u_timer (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .RUN(s_ff.init_done && s_ff.st != ST_SREF),
    .PERIOD(ref_period),
    .EXPIRE(expire)
  );

  // Split the access address by the programmed column width.
  always_comb begin
    column_address_bits = 4'(COL_BASE_BITS) + 4'(s_ff.cwf);
    acc_col = ACC_ADDR & ((27'h1 << column_address_bits) - 27'h1);
    acc_bank = ACC_ADDR >> column_address_bits;
    acc_row = ACC_ADDR >> (column_address_bits + 4'h2);
  end

  // A pulse still showing blocks a retake while the requester reacts.
  assign acc_go = ACC_REQ && !s_ff.done && !s_ff.err;

  // Status word; safe-to-change means idle with no access requested.
  always_comb begin
    state_word = '0;
    state_word[3:0] = s_ff.st;
    state_word[ST_INIT_BIT] = s_ff.init_done;
    state_word[ST_SREF_BIT] = (s_ff.st == ST_SREF);
    state_word[ST_IDLE_BIT] = (s_ff.st == ST_IDLE) && !ACC_REQ;
    state_word[ST_REFD_BIT] = s_ff.ref_due;
    state_word[ST_MRSD_BIT] = s_ff.mrs_due;
    state_word[ST_PAGE_LSB +: 13] = s_ff.page;
  end

  // Register file, command sequencer and refresh bookkeeping.
  always_comb begin
    n = s_ff;
    n.done = 1'b0;
    n.err = 1'b0;
    n.pins.cmd = CMD_NOP;
    n.pins.addr = '0;
    n.pins.ba = '0;
    if (s_ff.wait_cnt != 5'h0) begin
      n.wait_cnt = s_ff.wait_cnt - 5'h1;
    end
    unique case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.ref_due && s_ff.init_done) begin
          // Banks are closed after every transfer, so refresh is direct.
          n.st = ST_REF;
          n.pins.cmd = CMD_REF;
          n.wait_cnt = t_rc;
          n.ref_due = 1'b0;
        end else if (acc_go && !s_ff.ebe) begin
          n.err = 1'b1;
        end else if (acc_go && !s_ff.init_done && s_ff.powerup_sequence_enable) begin
          n.st = ST_INIT_PRE;
          n.pins.cmd = CMD_PRE;
          n.pins.addr[ADDR_A10_BIT] = 1'b1;
          n.wait_cnt = 5'(s_ff.trp);
          n.aref_left = INIT_AREF_NUM;
        end else if (acc_go && s_ff.mrs_due) begin
          n.st = ST_MRS;
        end else if (acc_go) begin
          n.st = ST_ACT;
        end else if (s_ff.self_refresh_request && s_ff.init_done) begin
          // Entering self-refresh is a refresh command with CKE low.
          n.st = ST_SREF;
          n.pins.cmd = CMD_REF;
          n.pins.cke = 1'b0;
        end
      end
      ST_INIT_PRE: begin
        if (s_ff.wait_cnt == 5'h0) begin
          n.st = s_ff.powerup_order_select ? ST_MRS : ST_INIT_REF;
        end
      end
      ST_INIT_REF: begin
        if (s_ff.wait_cnt == 5'h0) begin
          if (s_ff.aref_left != 4'h0) begin
            n.pins.cmd = CMD_REF;
            n.wait_cnt = t_rc;
            n.aref_left = s_ff.aref_left - 4'h1;
          end else begin
            n.st = s_ff.mrs_due ? ST_MRS : ST_ACT;
          end
        end
      end
      ST_MRS: begin
        // Command went out on entry; only the mode-set recovery runs.
        if (s_ff.wait_cnt == 5'h0) begin
          n.st = (s_ff.aref_left != 4'h0 && !s_ff.init_done) ?
                 ST_INIT_REF : ST_ACT;
        end
      end
      ST_ACT: begin
        if (s_ff.wait_cnt == 5'h0) begin
          n.st = ST_RW;
          n.pins.cmd = ACC_WRITE ? CMD_WR : CMD_RD;
          n.pins.ba = acc_bank[1:0];
          n.pins.addr = acc_col[12:0];
          n.wait_cnt = 5'(s_ff.tras);
          n.done = 1'b1;
        end
      end
      ST_RW: begin
        if (s_ff.wait_cnt == 5'h0) begin
          n.st = ST_PRE;
          n.pins.cmd = CMD_PRE;
          n.pins.addr[ADDR_A10_BIT] = 1'b1;
          n.wait_cnt = 5'(s_ff.trp);
        end
      end
      ST_PRE, ST_REF: begin
        if (s_ff.wait_cnt == 5'h0) begin
          n.st = ST_IDLE;
        end
      end
      ST_SREF: begin
        n.pins.cke = 1'b0;
        if (acc_go || !s_ff.self_refresh_request) begin
          // Exit waits row-active plus precharge before any command.
          n.st = ST_SREF_EXIT;
          n.pins.cke = 1'b1;
          n.wait_cnt = t_rc;
          n.self_refresh_request = 1'b0;
        end
      end
      ST_SREF_EXIT: begin
        if (s_ff.wait_cnt == 5'h0) begin
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // Opening commands go out on entry only, so a NOP during the
    // recovery wait can never make them repeat.
    if (n.st == ST_MRS && s_ff.st != ST_MRS) begin
      n.pins.cmd = CMD_MRS;
      n.pins.addr = '0;
      n.pins.addr[MR_CL_LSB +: 2] = s_ff.cl;
      n.wait_cnt = MRD_WAIT;
      n.mrs_due = 1'b0;
    end
    if (n.st == ST_ACT && s_ff.st != ST_ACT) begin
      n.init_done = 1'b1;
      n.pins.cmd = CMD_ACT;
      n.pins.ba = acc_bank[1:0];
      n.pins.addr = acc_row[12:0];
      n.wait_cnt = 5'(s_ff.trp);
    end
    // Expiry sets after the clear above, so an event is never lost.
    if (expire) begin
      n.ref_due = 1'b1;
    end
    // AHB data phase write; a bank or global write forces a new MRS.
    if (s_ff.dph_wr) begin
      unique case (s_ff.dph_ofs)
        OFS_RATE: begin
          n.refresh_divider = HWDATA[RATE_DIV_LSB +: 12];
        end
        OFS_BANK: begin
          n.ebe = HWDATA[BANK_EBE_BIT];
          n.cwf = HWDATA[BANK_CWF_LSB +: 2];
          n.mrs_due = 1'b1;
        end
        OFS_GLOBAL: begin
          n.tras = HWDATA[GC_TRAS_LSB +: 4];
          n.trp = HWDATA[GC_TRP_LSB +: 3];
          n.cl = HWDATA[GC_CL_LSB +: 2];
          n.powerup_order_select = HWDATA[GC_PSM_BIT];
          n.powerup_sequence_enable = HWDATA[GC_POWERUP_SEQUENCE_ENABLE_BIT];
          n.self_refresh_request = HWDATA[GC_SELF_REFRESH_REQUEST_BIT];
          n.mrs_due = 1'b1;
        end
        default: begin
        end
      endcase
    end
    n.page = PAGE_MIN_BYTES << n.cwf;
    // Address phase; read data is sampled now and shown next cycle.
    n.dph_wr = HSEL && HREADY && HTRANS[1] && HWRITE;
    n.dph_ofs = HADDR[7:0];
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      unique case (HADDR[7:0])
        OFS_RATE: n.rdata = {20'h0, s_ff.refresh_divider};
        OFS_BANK: n.rdata = {26'h0, s_ff.cwf, 3'h0, s_ff.ebe};
        OFS_GLOBAL: n.rdata = {17'h0, s_ff.self_refresh_request, s_ff.powerup_sequence_enable, s_ff.powerup_order_select,
                               2'h0, s_ff.cl, 1'h0, s_ff.trp, s_ff.tras};
        OFS_STATE: n.rdata = state_word;
        default: n.rdata = '0;
      endcase
    end
  end

  // State register; power-up leaves the memory owing a mode set.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_ff <= '{st: ST_IDLE, refresh_divider: RST_REFRESH_DIVIDER, tras: RST_TRAS, trp: RST_TRP,
                cl: RST_CL, mrs_due: 1'b1, page: PAGE_MIN_BYTES,
                pins: '{cke: 1'b1, cmd: CMD_NOP, default: '0},
                default: '0};
    end else begin
      s_ff <= n;
    end
  end

  assign HRDATA = s_ff.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign ACC_DONE = s_ff.done;
  assign ACC_ERR = s_ff.err;
  assign PAGE_BYTES = s_ff.page;
  assign SD_PINS = s_ff.pins;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence init_start_s;
    SD_PINS.cmd == CMD_PRE && s_ff.st == ST_INIT_PRE;
  endsequence
  sequence first_ref_s;
    s_ff.st == ST_INIT_REF && SD_PINS.cmd == CMD_REF;
  endsequence

  chk_page_size: assert property (PAGE_BYTES ==
    (PAGE_MIN_BYTES << s_ff.cwf))
    else $error("page size does not follow column width");
  chk_page_range: assert property (PAGE_BYTES inside
    {13'h0200, 13'h0400, 13'h0800, 13'h1000})
    else $error("page size outside supported set");
  chk_init_order: assert property (init_start_s ##1
    (s_ff.st == ST_INIT_PRE)[*1] ##[0:8] first_ref_s |-> !s_ff.powerup_order_select)
    else $error("auto-refresh followed precharge with order select set");
  chk_init_eight: assert property (SD_PINS.cmd == CMD_MRS &&
    !s_ff.init_done && !s_ff.powerup_order_select |-> s_ff.aref_left == 4'h0)
    else $error("mode set before eight init refreshes");
  chk_init_enable: assert property ($rose(s_ff.st == ST_INIT_PRE)
    |-> $past(s_ff.powerup_sequence_enable) && $past(ACC_REQ))
    else $error("power-up started without enable and access");
  chk_mrs_first: assert property (SD_PINS.cmd inside {CMD_RD, CMD_WR}
    |-> !s_ff.mrs_due)
    else $error("transfer issued while a mode set is owed");
  chk_mrs_burst: assert property (SD_PINS.cmd == CMD_MRS
    |-> SD_PINS.addr[3:0] == 4'h0)
    else $error("mode set not burst one sequential");
  chk_err_access: assert property (s_ff.st == ST_IDLE && acc_go &&
    !s_ff.ebe && !(s_ff.ref_due && s_ff.init_done) |=> ACC_ERR &&
    s_ff.st == ST_IDLE)
    else $error("disabled bank access not refused");
  chk_sref_cke: assert property (s_ff.st == ST_SREF |-> !SD_PINS.cke)
    else $error("clock enable high in self-refresh");
  chk_ref_issue: assert property (s_ff.st == ST_IDLE && s_ff.ref_due &&
    s_ff.init_done |=> SD_PINS.cmd == CMD_REF ##1 s_ff.st == ST_REF)
    else $error("owed refresh not issued from idle");
endmodule : sdrc_top

// ---- test/sdrc_sdram_model.sv ----
`timescale 1ns/1ps
module sdrc_sdram_model
  import sdrc_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst_n, // Reset, active low.
  input sdrc_pins_s pins, // Command pins from the controller.
  output logic [7:0] n_ref, // Auto-refreshes seen with clock enabled.
  output logic [7:0] n_mrs, // Mode register loads seen.
  output logic [7:0] n_act, // Row activations seen.
  output logic [7:0] ref_at_mrs, // Refresh count at the last mode load.
  output logic [12:0] mrs_addr, // Address of the last mode load.
  output logic [15:0] ref_gap, // Cycles between the last two refreshes.
  output logic pre_first // A precharge came before the first refresh.
);
  logic [15:0] cyc_ff;
  logic [15:0] last_ff;
  logic pre_ff;

  // The memory holds no data here, so only the command stream is kept.
  // A refresh with clock enable low is a self-refresh entry, not counted.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ff <= '0;
      last_ff <= '0;
      pre_ff <= 1'b0;
      n_ref <= '0;
      n_mrs <= '0;
      n_act <= '0;
      ref_at_mrs <= '0;
      mrs_addr <= '0;
      ref_gap <= '0;
      pre_first <= 1'b0;
    end else begin
      cyc_ff <= cyc_ff + 16'h0001;
      case (pins.cmd)
        CMD_PRE: pre_ff <= 1'b1;
        CMD_ACT: n_act <= n_act + 8'h01;
        CMD_MRS: begin
          n_mrs <= n_mrs + 8'h01;
          mrs_addr <= pins.addr;
          ref_at_mrs <= n_ref;
        end
        CMD_REF: if (pins.cke) begin
          n_ref <= n_ref + 8'h01;
          ref_gap <= cyc_ff - last_ff;
          last_ff <= cyc_ff;
          if (n_ref == 8'h00) pre_first <= pre_ff;
        end
        default: ;
      endcase
    end
  end
endmodule : sdrc_sdram_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import sdrc_pkg::*;
;
  logic clock, rst_n, hsel, hwrite, hreadyout, hresp;
  logic acc_req, acc_write, acc_done, acc_err, pre_first, err;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [26:0] acc_addr;
  logic [12:0] page_bytes, mrs_addr;
  logic [7:0] n_ref, n_mrs, n_act, ref_at_mrs;
  logic [15:0] ref_gap;
  logic [3:0] cmd;
  sdrc_pins_s sd_pins;
  int failures, num_checks, base;

  // The slave's own ready feeds the bus ready, as on a one-slave bus.
  sdrc_top u_sdrc_top (.CLOCK(clock), .RST_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .ACC_REQ(acc_req),
    .ACC_WRITE(acc_write), .ACC_ADDR(acc_addr), .ACC_DONE(acc_done),
    .ACC_ERR(acc_err), .PAGE_BYTES(page_bytes), .SD_PINS(sd_pins));
  sdrc_sdram_model u_sdrc_sdram_model (.clock(clock), .rst_n(rst_n),
    .pins(sd_pins), .n_ref(n_ref), .n_mrs(n_mrs), .n_act(n_act),
    .ref_at_mrs(ref_at_mrs), .mrs_addr(mrs_addr), .ref_gap(ref_gap),
    .pre_first(pre_first));

  // A 25 ns period gives the 40 MHz system clock.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic conclude;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bail(input logic ok);
    if (!ok) begin
      failures++;
      conclude();
    end
  endtask : bail

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    bail(hreadyout === 1'b1);
  endtask : wait_rdy

  // One single word transfer; read data is taken at the data-phase edge.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  // The request is held until a pulse shows, then dropped next edge.
  task automatic access(input logic wr, input logic [26:0] a);
    int n;
    n = 0;
    @(posedge clock);
    acc_req <= 1'b1;
    acc_write <= wr;
    acc_addr <= a;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (acc_done !== 1'b1 && acc_err !== 1'b1 && n < 400);
    bail(acc_done === 1'b1 || acc_err === 1'b1);
    err = acc_err;
    cmd = sd_pins.cmd;
    @(posedge clock);
    acc_req <= 1'b0;
  endtask : access

  initial begin
    {hsel, hwrite, acc_req, acc_write, rst_n} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    acc_addr = '0;
    failures = 0;
    num_checks = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    ahb(1'b0, OFS_RATE, '0);
    chk(rd, 32'h000000FF);
    ahb(1'b0, OFS_GLOBAL, '0);
    chk(rd, 32'h00000211);
    ahb(1'b0, OFS_STATE, '0);
    chk(rd[28:16], 32'h200);
    chk(rd[8], 1);
    ahb(1'b0, 8'h10, '0);
    chk(rd, 0);
    // With the bank disabled no command may reach the memory.
    access(1'b0, 27'h0000123);
    chk(err, 1);
    chk({n_act, n_mrs, n_ref}, 0);
    // Power-up: precharge, eight refreshes, then the mode load.
    ahb(1'b1, OFS_GLOBAL, 32'h00002211);
    ahb(1'b1, OFS_BANK, 32'h00000011);
    access(1'b0, 27'h0010200);
    chk(cmd, CMD_RD);
    chk(pre_first, 1);
    chk(ref_at_mrs, 8);
    chk(mrs_addr[3:0], 0);
    chk(mrs_addr[5:4], 2);
    chk(n_mrs, 1);
    chk(page_bytes, 32'h400);
    // Every column width gives its own page size.
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, OFS_BANK, 32'h1 | (i << 4));
      ahb(1'b0, OFS_STATE, '0);
      chk(rd[28:16], 32'h200 << i);
      chk(page_bytes, 32'h200 << i);
    end
    chk(rd[8], 1);
    base = n_mrs;
    access(1'b1, 27'h0000040);
    chk(cmd, CMD_WR);
    chk(n_mrs, base + 1);
    access(1'b1, 27'h0000044);
    chk(n_mrs, base + 1);
    ahb(1'b0, OFS_STATE, '0);
    chk(rd[4], 1);
    chk(rd[8], 0);
    // Self-refresh parks the memory until the next access wakes it.
    ahb(1'b1, OFS_GLOBAL, 32'h00006211);
    for (int n = 0; n < 300 && sd_pins.cke !== 1'b0; n++) @(posedge clock);
    bail(sd_pins.cke === 1'b0);
    ahb(1'b0, OFS_STATE, '0);
    chk(rd[5], 1);
    chk(rd[3:0], ST_SREF);
    access(1'b0, 27'h0000080);
    chk(cmd, CMD_RD);
    chk(sd_pins.cke, 1);
    ahb(1'b0, OFS_GLOBAL, '0);
    chk(rd[14], 0);
    // A short divider: the third gap is free of the old period.
    ahb(1'b1, OFS_RATE, 32'h00000014);
    base = n_ref;
    for (int n = 0; n < 1000 && n_ref < base + 3; n++) @(posedge clock);
    bail(n_ref >= base + 3);
    chk(ref_gap, 22);
    conclude();
  end
endmodule : tb_top
